// ---- spd_defs.svh ----
// Purpose: Constants for the power-down command decoder.
// Assumes: Included by the decoder and the bench only.
// Notes:   Strobe patterns are {ras_n, cas_n, we_n}.
`ifndef SPD_DEFS_SVH
`define SPD_DEFS_SVH
`define SPD_PAT_MRW      3'h0
`define SPD_PAT_REF      3'h1
`define SPD_PAT_PRE      3'h2
`define SPD_PAT_ACT      3'h3
`define SPD_PAT_WR       3'h4
`define SPD_PAT_RD       3'h5
`define SPD_PAT_NOP      3'h7
`define SPD_AP_BIT       10
`define SPD_BURST_LEN    4
`define SPD_BANKS        4
`define SPD_BANK_W       2
`define SPD_ADDR_W       14
`endif

// ---- spd_pkg.sv ----
// Purpose: Types for the power-down command decoder.
// Assumes: spd_defs.svh holds the numeric constants.
// Notes:   Power states are one-hot.
package spd_pkg;
  typedef enum logic [3:0] {
    SPD_IDLE   = 4'h1,
    SPD_PPD    = 4'h2,
    SPD_APD    = 4'h4,
    SPD_SREF   = 4'h8
  } spd_state_type;
  typedef enum logic [3:0] {
    SPD_C_NONE = 4'h0,
    SPD_C_NOP  = 4'h1,
    SPD_C_MRW  = 4'h2,
    SPD_C_REF  = 4'h3,
    SPD_C_PRE  = 4'h4,
    SPD_C_PREA = 4'h5,
    SPD_C_ACT  = 4'h6,
    SPD_C_WR   = 4'h7,
    SPD_C_RD   = 4'h8,
    SPD_C_SRE  = 4'h9,
    SPD_C_SRX  = 4'hA,
    SPD_C_PDE  = 4'hB,
    SPD_C_PDX  = 4'hC
  } spd_cmd_type;
  typedef struct packed {
    logic       cs_n;
    logic       ras_n;
    logic       cas_n;
    logic       we_n;
    logic [1:0] bank;
    logic [13:0] addr;
  } spd_bus_type;
  typedef struct packed {
    spd_cmd_type cmd;
    logic [1:0]  bank;
    logic [13:0] addr;
    logic        auto_pre;
  } spd_dec_type;
endpackage : spd_pkg

// ---- spd_powerdown_decode.sv ----
// Purpose: Command decode and power-state control of a synchronous DRAM.
// Assumes: Controller keeps clock-enable timing, refresh and sequencing.
// Notes:   Array, burst data path and delay-locked loop itself are outside.
`timescale 1ns/1ns
`include "spd_defs.svh"

module spd_powerdown_decode
  import spd_pkg::*;
#(
  parameter int BANKS = `SPD_BANKS
)(
  input  wire logic        clock_i,
  input  wire logic        rst_b_i,
  input  wire logic        clk_en_i,
  input  wire logic        cke_i,
  input  wire spd_bus_type bus_i,
  input  wire logic        termination_enable_i,
  input  wire logic        fast_exit_i,
  output logic             buffers_on_o,
  output logic             dll_enable_o,
  output logic             odt_active_o,
  output logic             refresh_allowed_o,
  output logic             array_suspect_o,
  output spd_dec_type      cmd_o,
  output logic             burst_busy_o,
  output logic             mode_write_o,
  output logic [1:0]       mode_sel_o,
  output logic [13:0]      mode_op_o,
  output spd_state_type    state_o
);

  // ****************************************************************
  // Reset release
  // ****************************************************************
  logic rst_s1_q;
  logic rst_s2_q;
  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end
    else
    begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end
  wire logic rst_n = rst_s2_q;

  // ****************************************************************
  // Self-refresh exit seen without a clock edge
  // ****************************************************************
  // The clock may be stopped in self refresh, so the rising enable sets a
  // flag asynchronously; it is cleared once the clocked logic has left.
  logic sr_wake_q;
  logic in_sref;
  wire logic sr_arm_n = rst_n && in_sref;
  always_ff @(posedge cke_i or negedge sr_arm_n)
  begin
    if (!sr_arm_n)
      sr_wake_q <= 1'b0;
    else
      sr_wake_q <= 1'b1;
  end
  logic sr_wake_s1_q;
  logic sr_wake_s2_q;

  // ****************************************************************
  // Command decode
  // ****************************************************************
  logic        cke_prev_q;
  spd_dec_type dec;
  logic        nop_like;
  always_comb
  begin
    nop_like     = bus_i.cs_n || ({bus_i.ras_n, bus_i.cas_n, bus_i.we_n} == `SPD_PAT_NOP);
    dec.bank     = bus_i.bank;
    dec.addr     = bus_i.addr;
    dec.auto_pre = bus_i.addr[`SPD_AP_BIT];
    dec.cmd      = SPD_C_NONE;
    if (cke_prev_q && cke_i)
    begin
      if (nop_like)
        dec.cmd = SPD_C_NOP;
      else
      begin
        unique case ({bus_i.ras_n, bus_i.cas_n, bus_i.we_n})
          `SPD_PAT_MRW: dec.cmd = SPD_C_MRW;
          `SPD_PAT_REF: dec.cmd = SPD_C_REF;
          `SPD_PAT_PRE: dec.cmd = bus_i.addr[`SPD_AP_BIT] ? SPD_C_PREA : SPD_C_PRE;
          `SPD_PAT_ACT: dec.cmd = SPD_C_ACT;
          `SPD_PAT_WR:  dec.cmd = SPD_C_WR;
          `SPD_PAT_RD:  dec.cmd = SPD_C_RD;
          default:      dec.cmd = SPD_C_NONE;
        endcase
      end
    end
    else if (cke_prev_q && !cke_i)
    begin
      if (nop_like)
        dec.cmd = SPD_C_PDE;
      else if (!bus_i.cs_n && {bus_i.ras_n, bus_i.cas_n, bus_i.we_n} == `SPD_PAT_REF)
        dec.cmd = SPD_C_SRE;
    end
    else if (!cke_prev_q && cke_i && nop_like)
      dec.cmd = SPD_C_PDX;
  end

  // ****************************************************************
  // Power state, bank tracking and burst guard
  // ****************************************************************
  spd_state_type state_q, state_d;
  logic [BANKS-1:0] open_q, open_d;
  logic [1:0]  burst_q, burst_d;
  logic        suspect_q, suspect_d;
  logic        dll_q, dll_d;
  spd_dec_type cmd_q, cmd_d;
  logic        mw_q, mw_d;
  logic [1:0]  msel_q, msel_d;
  logic [13:0] mop_q, mop_d;
  logic        accept;

  always_comb
  begin
    state_d   = state_q;
    open_d    = open_q;
    burst_d   = (burst_q != 2'h0) ? burst_q - 2'h1 : 2'h0;
    suspect_d = suspect_q;
    dll_d     = dll_q;
    cmd_d     = dec;
    mw_d      = 1'b0;
    msel_d    = msel_q;
    mop_d     = mop_q;
    // Commands other than no-operation are dropped while a burst is running.
    accept    = (burst_q == 2'h0) || (dec.cmd == SPD_C_NOP);
    if (!accept)
      cmd_d.cmd = SPD_C_NONE;
    // Enable falling mid-burst or mid-write is the unexpected drop.
    if (cke_prev_q && !cke_i && burst_q != 2'h0)
      suspect_d = 1'b1;
    if (dec.cmd == SPD_C_MRW && accept)
      suspect_d = 1'b0;
    unique case (state_q)
      SPD_IDLE:
      begin
        dll_d = 1'b1;
        if (accept)
        begin
          unique case (dec.cmd)
            SPD_C_ACT:  open_d[dec.bank] = 1'b1;
            SPD_C_PRE:  open_d[dec.bank] = 1'b0;
            SPD_C_PREA: open_d = '0;
            SPD_C_WR, SPD_C_RD:
            begin
              burst_d = 2'(`SPD_BURST_LEN / 2 - 1);
              if (dec.auto_pre)
                open_d[dec.bank] = 1'b0;
            end
            SPD_C_MRW:
            begin
              mw_d   = 1'b1;
              msel_d = dec.bank;
              mop_d  = dec.addr;
            end
            SPD_C_PDE:
            begin
              state_d = (open_q == '0) ? SPD_PPD : SPD_APD;
              dll_d   = (open_q != '0) && fast_exit_i;
            end
            SPD_C_SRE:
            begin
              state_d = SPD_SREF;
              dll_d   = 1'b0;
            end
            default: ;
          endcase
        end
      end
      SPD_PPD, SPD_APD:
      begin
        if (dec.cmd == SPD_C_PDX)
        begin
          state_d = SPD_IDLE;
          dll_d   = 1'b1;
        end
      end
      SPD_SREF:
      begin
        if (sr_wake_s2_q && cke_i)
        begin
          state_d = SPD_IDLE;
          dll_d   = 1'b1;
        end
      end
      default: state_d = SPD_IDLE;
    endcase
  end

  assign in_sref = (state_q == SPD_SREF);

  always_ff @(posedge clock_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q      <= SPD_IDLE;
      open_q       <= '0;
      burst_q      <= 2'h0;
      suspect_q    <= 1'b0;
      dll_q        <= 1'b1;
      cmd_q        <= '0;
      mw_q         <= 1'b0;
      msel_q       <= 2'h0;
      mop_q        <= 14'h0000;
      cke_prev_q   <= 1'b0;
      sr_wake_s1_q <= 1'b0;
      sr_wake_s2_q <= 1'b0;
    end
    else if (clk_en_i)
    begin
      state_q      <= state_d;
      open_q       <= open_d;
      burst_q      <= burst_d;
      suspect_q    <= suspect_d;
      dll_q        <= dll_d;
      cmd_q        <= cmd_d;
      mw_q         <= mw_d;
      msel_q       <= msel_d;
      mop_q        <= mop_d;
      cke_prev_q   <= cke_i;
      sr_wake_s1_q <= sr_wake_q && in_sref;
      sr_wake_s2_q <= sr_wake_s1_q;
    end
  end

  // ****************************************************************
  // Registered outputs
  // ****************************************************************
  logic buf_q;
  logic odt_q;
  logic ref_q;
  logic busy_q;
  always_ff @(posedge clock_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      buf_q <= 1'b1;
      odt_q <= 1'b0;
      ref_q <= 1'b1;
      busy_q <= 1'b0;
    end
    else if (clk_en_i)
    begin
      buf_q <= (state_d == SPD_IDLE);
      odt_q <= termination_enable_i && (state_d != SPD_SREF);
      ref_q <= (state_d == SPD_IDLE);
      busy_q <= (burst_d != 2'h0);
    end
  end

  assign buffers_on_o      = buf_q;
  assign dll_enable_o      = dll_q;
  assign odt_active_o      = odt_q;
  assign refresh_allowed_o = ref_q;
  assign array_suspect_o   = suspect_q;
  assign cmd_o             = cmd_q;
  assign burst_busy_o      = busy_q;
  assign mode_write_o      = mw_q;
  assign mode_sel_o        = msel_q;
  assign mode_op_o         = mop_q;
  assign state_o           = state_q;

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_ppd_class: assert property (@(posedge clock_i) disable iff (!rst_n)
    (clk_en_i && state_q == SPD_IDLE && dec.cmd == SPD_C_PDE && accept && open_q == '0)
      |=> state_q == SPD_PPD)
    else $error("Idle-bank power-down not precharge type.");
  a_apd_class: assert property (@(posedge clock_i) disable iff (!rst_n)
    (clk_en_i && state_q == SPD_IDLE && dec.cmd == SPD_C_PDE && accept && open_q != '0)
      |=> state_q == SPD_APD)
    else $error("Open-bank power-down not active type.");
  a_buf_off: assert property (@(posedge clock_i) disable iff (!rst_n)
    (state_q != SPD_IDLE) |-> !buffers_on_o)
    else $error("Buffers on during power-down.");
  a_dll_ppd: assert property (@(posedge clock_i) disable iff (!rst_n)
    (state_q == SPD_PPD || state_q == SPD_SREF) |-> !dll_enable_o)
    else $error("Loop enabled in precharge power-down.");
  a_pd_exit: assert property (@(posedge clock_i) disable iff (!rst_n)
    (clk_en_i && (state_q == SPD_PPD || state_q == SPD_APD) && dec.cmd == SPD_C_PDX)
      |=> state_q == SPD_IDLE)
    else $error("Power-down exit missed.");
  a_burst_hold: assert property (@(posedge clock_i) disable iff (!rst_n)
    (clk_en_i && cmd_d.cmd == SPD_C_RD && !$past(burst_busy_o) && burst_q == 2'h0)
      |=> burst_busy_o)
    else $error("Burst not started.");
  a_no_refresh: assert property (@(posedge clock_i) disable iff (!rst_n)
    $past(state_q) != SPD_IDLE && state_q != SPD_IDLE |-> !refresh_allowed_o)
    else $error("Refresh allowed during power-down.");
  a_odt_sref: assert property (@(posedge clock_i) disable iff (!rst_n)
    (state_q == SPD_SREF && $past(state_q) == SPD_SREF) |-> !odt_active_o)
    else $error("Termination active in self refresh.");
  a_mode_write: assert property (@(posedge clock_i) disable iff (!rst_n)
    (clk_en_i && state_q == SPD_IDLE && dec.cmd == SPD_C_MRW && accept)
      |=> mode_write_o && mode_sel_o == $past(bus_i.bank))
    else $error("Mode write not loaded.");

endmodule : spd_powerdown_decode

// ---- spd_ctrl_model.sv ----
// Purpose: Memory controller model driving clock enable and command lines.
// Assumes: The bench calls put once per cycle from one process.
// Notes:   Every line is always driven to a defined level.
`timescale 1ns/1ns
module spd_ctrl_model
  import spd_pkg::*;
(
  input  wire logic   clock_i,
  output spd_bus_type bus_o,
  output logic        cke_o
);
  // ****************************************
  // Command issue
  // ****************************************
  initial
  begin
    cke_o = 1'b1;
    bus_o = {4'h7, 2'h0, 14'h0000};
  end

  // The bench keeps each enable level at least three cycles and power-down short,
  // so the refresh budget is never at risk.
  task automatic put(
    input logic        cke_v,
    input logic [3:0]  pat,
    input logic [1:0]  bank,
    input logic [13:0] addr
  );
    @(posedge clock_i);
    cke_o <= cke_v;
    bus_o <= {pat, bank, addr};
  endtask : put
endmodule : spd_ctrl_model

// ---- spd_powerdown_decode_tb_top.sv ----
// Purpose: Self-checking bench of the power-down command decoder.
// Assumes: Outputs settle on the same edge that takes a command.
// Notes:   Patterns are {cs_n, ras_n, cas_n, we_n}.
`timescale 1ns/1ns
`include "spd_defs.svh"
module spd_powerdown_decode_tb_top
  import spd_pkg::*;
;
  logic          clock_i = 1'b0;
  logic          rst_b_i = 1'b0;
  logic          clk_en_i = 1'b1;
  logic          termination_enable_i = 1'b0;
  logic          fast_exit_i = 1'b0;
  spd_bus_type   bus;
  logic          cke;
  logic          buffers_on_o;
  logic          dll_enable_o;
  logic          odt_active_o;
  logic          refresh_allowed_o;
  logic          array_suspect_o;
  spd_dec_type   cmd_o;
  logic          burst_busy_o;
  logic          mode_write_o;
  logic [1:0]    mode_sel_o;
  logic [13:0]   mode_op_o;
  spd_state_type state_o;
  int            n_errors = 0;
  int            samples_checked = 0;
  int            cycles = 0;

  // The clock keeps one frequency, so no frequency change or loop reset is needed.
  always #4 clock_i = ~clock_i;

  spd_ctrl_model i_spd_ctrl_model (.clock_i(clock_i), .bus_o(bus), .cke_o(cke));

  spd_powerdown_decode i_spd_powerdown_decode (
    .clock_i(clock_i), .rst_b_i(rst_b_i), .clk_en_i(clk_en_i), .cke_i(cke),
    .bus_i(bus), .termination_enable_i(termination_enable_i),
    .fast_exit_i(fast_exit_i), .buffers_on_o(buffers_on_o),
    .dll_enable_o(dll_enable_o), .odt_active_o(odt_active_o),
    .refresh_allowed_o(refresh_allowed_o), .array_suspect_o(array_suspect_o),
    .cmd_o(cmd_o), .burst_busy_o(burst_busy_o), .mode_write_o(mode_write_o),
    .mode_sel_o(mode_sel_o), .mode_op_o(mode_op_o), .state_o(state_o)
  );

  // ****************************************
  // Helpers
  // ****************************************
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("ERROR %s expected %0h seen %0h", name, exp, seen);
    end
  endtask : chk

  task automatic nop(input logic c);
    i_spd_ctrl_model.put(c, 4'h7, 2'h0, 14'h0000);
  endtask : nop

  task automatic summarize;
    $display("Checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : summarize

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_decode;
    logic [3:0]  pats[7] = '{4'h0, 4'h1, 4'h2, 4'h2, 4'h3, 4'h4, 4'h5};
    logic [13:0] adrs[7] = '{14'h1234, 14'h0000, 14'h0000, 14'h0400, 14'h0055, 14'h0405,
                             14'h0012};
    spd_cmd_type exps[7] = '{SPD_C_MRW, SPD_C_REF, SPD_C_PRE, SPD_C_PREA, SPD_C_ACT,
                             SPD_C_WR, SPD_C_RD};
    for (int i = 0; i < 7; i++)
    begin
      i_spd_ctrl_model.put(1'b1, pats[i], 2'h2, adrs[i]);
      nop(1'b1);
      #1;
      chk("cmd", cmd_o.cmd, exps[i]);
      chk("cmd_fields", {cmd_o.bank, cmd_o.addr}, {2'h2, adrs[i]});
      if (i >= 5)
        chk("auto_pre", cmd_o.auto_pre, adrs[i][`SPD_AP_BIT]);
      if (i == 0)
        chk("mode_sel", {mode_write_o, mode_sel_o, mode_op_o}, {1'b1, 2'h2, 14'h1234});
      nop(1'b1);
      nop(1'b1);
    end
  endtask : t_decode

  task automatic t_burst;
    i_spd_ctrl_model.put(1'b1, 4'h5, 2'h1, 14'h0010);
    i_spd_ctrl_model.put(1'b1, 4'h4, 2'h1, 14'h0010);
    #1;
    chk("burst_busy", burst_busy_o, 1'b1);
    nop(1'b1);
    #1;
    chk("refused", cmd_o.cmd, SPD_C_NONE);
    i_spd_ctrl_model.put(1'b1, 4'h5, 2'h1, 14'h0010);
    i_spd_ctrl_model.put(1'b1, 4'h8, 2'h0, 14'h0000);
    nop(1'b1);
    #1;
    chk("deselect_in_burst", cmd_o.cmd, SPD_C_NOP);
    nop(1'b1);
    #1;
    chk("nop", cmd_o.cmd, SPD_C_NOP);
  endtask : t_burst

  task automatic t_pd(input logic fx, input spd_state_type st, input logic dll);
    @(posedge clock_i);
    fast_exit_i <= fx;
    nop(1'b0);
    nop(1'b0);
    #1;
    chk("pd_state", state_o, st);
    chk("pd_outs", {buffers_on_o, dll_enable_o, refresh_allowed_o}, {1'b0, dll, 1'b0});
    nop(1'b0);
    nop(1'b0);
    nop(1'b1);
    nop(1'b1);
    #1;
    chk("pd_exit", {state_o, buffers_on_o, refresh_allowed_o}, {SPD_IDLE, 2'h3});
    nop(1'b1);
    nop(1'b1);
  endtask : t_pd

  task automatic wake;
    nop(1'b1);
    for (int i = 0; i < 12 && state_o !== SPD_IDLE; i++)
      nop(1'b1);
    nop(1'b1);
  endtask : wake

  task automatic t_sref;
    @(posedge clock_i);
    termination_enable_i <= 1'b1;
    nop(1'b1);
    nop(1'b1);
    #1;
    chk("odt_idle", odt_active_o, 1'b1);
    i_spd_ctrl_model.put(1'b0, 4'h1, 2'h0, 14'h0000);
    nop(1'b0);
    #1;
    chk("sref", {state_o, odt_active_o, refresh_allowed_o}, {SPD_SREF, 2'h0});
    nop(1'b0);
    nop(1'b0);
    wake();
    chk("sref_exit", state_o, SPD_IDLE);
    termination_enable_i <= 1'b0;
  endtask : t_sref

  task automatic t_drop;
    i_spd_ctrl_model.put(1'b1, 4'h5, 2'h0, 14'h0020);
    nop(1'b0);
    nop(1'b0);
    #1;
    chk("suspect", array_suspect_o, 1'b1);
    nop(1'b0);
    nop(1'b0);
    wake();
    i_spd_ctrl_model.put(1'b1, 4'h0, 2'h1, 14'h0003);
    nop(1'b1);
    #1;
    chk("suspect_clr", array_suspect_o, 1'b0);
  endtask : t_drop

  task automatic t_unlisted;
    i_spd_ctrl_model.put(1'b1, 4'h6, 2'h0, 14'h0000);
    nop(1'b1);
    #1;
    chk("unlisted", {cmd_o.cmd, state_o}, {SPD_C_NONE, SPD_IDLE});
  endtask : t_unlisted

  // ****************************************
  // Main sequence
  // ****************************************
  always @(posedge clock_i)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      n_errors++;
      summarize();
    end
  end

  initial
  begin
    repeat (20) @(posedge clock_i);
    rst_b_i <= 1'b1;
    repeat (5) nop(1'b1);
    #1;
    chk("reset_outs", {state_o, buffers_on_o, dll_enable_o, refresh_allowed_o},
        {SPD_IDLE, 3'h7});
    t_decode();
    t_burst();
    // Open a row so that the next two power-downs are of the active kind.
    i_spd_ctrl_model.put(1'b1, 4'h3, 2'h1, 14'h0100);
    nop(1'b1);
    t_pd(1'b1, SPD_APD, 1'b1);
    t_pd(1'b0, SPD_APD, 1'b0);
    i_spd_ctrl_model.put(1'b1, 4'h2, 2'h0, 14'h0400);
    nop(1'b1);
    t_pd(1'b1, SPD_PPD, 1'b0);
    t_sref();
    t_drop();
    t_unlisted();
    summarize();
  end
endmodule : spd_powerdown_decode_tb_top
